// >>> rtl/pll_cfg.svh
// Field positions, latch addresses and timing counts for the synthesizer program port.
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH

`define WORD_W 32
`define SEL_MSB 3
`define SEL_LSB 0
`define LATCH_COUNT 9
`define LATCH_LAST 4'h8
`define SEL_R0 4'h0
`define SEL_R1 4'h1
`define SEL_R2 4'h2
`define SEL_R4 4'h4
`define SEL_R6 4'h6

// Register 0.
`define INT_MSB 19
`define INT_LSB 4
`define PRESC_BIT 20
`define INT_MIN_45 16'h0017
`define INT_MAX_45 16'h7FFF
`define INT_MIN_89 16'h004B
// Register 1.
`define PRIMARY_FRACTION_NUMERATOR_MSB 27
`define PRIMARY_FRACTION_NUMERATOR_LSB 4
// Register 2.
`define AUXILIARY_FRACTION_NUMERATOR_MSB 17
`define AUXILIARY_FRACTION_NUMERATOR_LSB 4
`define AUXILIARY_MODULUS_MSB 31
`define AUXILIARY_MODULUS_LSB 18
`define AUXILIARY_MODULUS_MIN 14'h0002
// Register 4.
`define RCNT_MSB 13
`define RCNT_LSB 4
`define HALF_BIT 14
`define DBL_BIT 15
`define CP_MSB 19
`define CP_LSB 16
`define RSEL_BIT 20
`define MON_MSB 29
`define MON_LSB 27
// Register 6.
`define PWR_MSB 5
`define PWR_LSB 4
`define RFEN_BIT 6
`define MUTE_UNTIL_LOCK_BIT 11
`define REFDIFF_BIT 30

// Host side: 20 MHz system clock, serial clock half period of 100 ns.
`define CLK_PERIOD_NS 50
`define SCLK_HALF_NS 100
`define SCLK_HALF_CYCLES ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOST_DATA_ADDR 4'h0
`define HOST_STATUS_ADDR 4'h4
`define STAT_BUSY 0
`define STAT_R0_PENDING 1
`define STAT_RANGE_ERR 2

`endif

// >>> rtl/pll_pkg.sv
// Types shared by both ends of the synthesizer program port.
package pll_pkg;
    typedef logic [31:0] word_t;

    typedef enum logic [2:0] {
        MON_OFF,
        MON_HIGH,
        MON_LOW,
        MON_R_DIV,
        MON_N_DIV,
        MON_LOCK_ANALOG,
        MON_LOCK_DIGITAL,
        MON_SPARE
    } monitor_sel_t;

    typedef enum {
        HOST_IDLE,
        HOST_SHIFT,
        HOST_LOAD
    } host_state_t;
endpackage

// >>> rtl/serial_prog_if.sv
// Three-wire serial program link between host controller and synthesizer core.
`timescale 1ns/10ps
interface serial_prog_if;
    logic sclk;
    logic sdata;
    logic load_strobe;

    modport host (output sclk, output sdata, output load_strobe);
    modport device (input sclk, input sdata, input load_strobe);
endinterface

// >>> rtl/synth_ctrl_core.sv
// Synthesizer digital core: serial shift register, nine latches, dividers and output control.
//
// Function
// - One bit shifted per serial clock rise, MSB first.
// - Load strobe rise copies word into one latch.
// - Low four bits address latches 0 to 8.
// - Fractions, modulus, reference and pump settings are held.
// - Held settings become active on register 0 write.
// - Register 6 bit 30 selects differential reference.
// - Ratio is whole plus fractions over fixed modulus.
// - Whole value 16 bits, range set by prescaler.
// - Auxiliary modulus is 14 bits, 2 upward.
// - Both numerators zero means pure integer mode.
// - Reference counter divides by 1 to 1023.
// - Detector rate is reference times doubler over counter times halving.
// - Three monitor select bits drive the monitor pin.
// - Host should leave RF output stage disabled; host sends register 6 bit 6 as written and core enables RF from it.
// - Two bits select one of four power levels.
// - Mute-until-lock holds RF off until digital lock.
// - Low power-down pin mutes RF outputs.
`timescale 1ns/10ps
`include "pll_cfg.svh"

module synth_ctrl_core
    import pll_pkg::*;
(
    // System.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Serial program link.
    serial_prog_if.device link,
    // Analog-side events and status.
    input wire logic ref_tick,
    input wire logic n_tick,
    input wire logic lock_analog,
    input wire logic lock_digital,
    input wire logic rf_power_down_pin_b,
    // Active feedback divider settings.
    output logic [15:0] int_value,
    output logic prescaler_8_9,
    output logic [23:0] primary_fraction_numerator,
    output logic [13:0] auxiliary_fraction_numerator,
    output logic [13:0] auxiliary_modulus,
    output logic integer_mode,
    output logic n_range_error,
    // Active reference path settings.
    output logic [9:0] r_count,
    output logic reference_doubler,
    output logic reference_half_divide,
    output logic [3:0] cp_current,
    output logic r_div_select,
    output logic reference_differential,
    output logic pfd_tick,
    // Monitor and RF output control.
    output logic monitor_output_pin,
    output logic rf_out_on,
    output logic [1:0] rf_power_level
);

    logic sclk_q;
    logic load_q;
    word_t shift_word;
    word_t latch [0:`LATCH_COUNT-1];
    logic load_rise;
    logic [3:0] sel;
    logic [11:0] acc;
    logic [11:0] next_acc;
    logic [10:0] r_threshold;
    logic [9:0] r_eff;
    logic [1:0] step;
    monitor_sel_t mon_sel;

    assign load_rise = link.load_strobe & ~load_q;
    assign sel = shift_word[`SEL_MSB:`SEL_LSB];

    // Inputs are synchronous to clk_sys, so a one-flop history is enough for edge detection.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sclk_q <= 1'b0;
            load_q <= 1'b0;
        end
        else
        begin
            sclk_q <= link.sclk;
            load_q <= link.load_strobe;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            shift_word <= 32'h00000000;
        else if (link.sclk && !sclk_q)
            shift_word <= {shift_word[30:0], link.sdata};
    end

    // Latches 1, 2 and 4 are holding stages for the double-buffered fields.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `LATCH_COUNT; i++)
                latch[i] <= 32'h00000000;
        end
        else if (load_rise && sel <= `LATCH_LAST)
        begin
            latch[sel] <= shift_word;
        end
    end

    // Whole value and prescaler act directly from register 0.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            int_value <= 16'h0000;
            prescaler_8_9 <= 1'b0;
        end
        else if (load_rise && sel == `SEL_R0)
        begin
            int_value <= shift_word[`INT_MSB:`INT_LSB];
            prescaler_8_9 <= shift_word[`PRESC_BIT];
        end
    end

    // Held settings move to their active copies only on a register 0 write.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            primary_fraction_numerator <= 24'h000000;
            auxiliary_fraction_numerator <= 14'h0000;
            auxiliary_modulus <= 14'h0000;
            r_count <= 10'h000;
            reference_doubler <= 1'b0;
            reference_half_divide <= 1'b0;
            cp_current <= 4'h0;
            r_div_select <= 1'b0;
        end
        else if (load_rise && sel == `SEL_R0)
        begin
            primary_fraction_numerator <= latch[1][`PRIMARY_FRACTION_NUMERATOR_MSB:`PRIMARY_FRACTION_NUMERATOR_LSB];
            auxiliary_fraction_numerator <= latch[2][`AUXILIARY_FRACTION_NUMERATOR_MSB:`AUXILIARY_FRACTION_NUMERATOR_LSB];
            auxiliary_modulus <= latch[2][`AUXILIARY_MODULUS_MSB:`AUXILIARY_MODULUS_LSB];
            r_count <= latch[4][`RCNT_MSB:`RCNT_LSB];
            reference_doubler <= latch[4][`DBL_BIT];
            reference_half_divide <= latch[4][`HALF_BIT];
            cp_current <= latch[4][`CP_MSB:`CP_LSB];
            r_div_select <= latch[4][`RSEL_BIT];
        end
    end

    // The ratio itself is realised by the analog N counter; these flags summarise it.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            integer_mode <= 1'b1;
            n_range_error <= 1'b0;
        end
        else
        begin
            integer_mode <= (primary_fraction_numerator == 24'h000000)
                && (auxiliary_fraction_numerator == 14'h0000);
            n_range_error <= prescaler_8_9 ? (int_value < `INT_MIN_89)
                : (int_value < `INT_MIN_45 || int_value > `INT_MAX_45);
        end
    end

    // Fractional accumulation gives an exact average of (1+D)/(R*(1+T)) pulses per ref tick when that ratio is at most one.
    always_comb
    begin
        r_eff = (r_count == 10'h000) ? 10'h001 : r_count;
        r_threshold = reference_half_divide ? {r_eff, 1'b0} : {1'b0, r_eff};
        step = reference_doubler ? 2'h2 : 2'h1;
        next_acc = acc + {10'h000, step};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            acc <= 12'h000;
            pfd_tick <= 1'b0;
        end
        else if (ref_tick)
        begin
            if (next_acc >= {1'b0, r_threshold})
            begin
                acc <= next_acc - {1'b0, r_threshold};
                pfd_tick <= 1'b1;
            end
            else
            begin
                acc <= next_acc;
                pfd_tick <= 1'b0;
            end
        end
        else
        begin
            pfd_tick <= 1'b0;
        end
    end

    assign mon_sel = monitor_sel_t'(latch[4][`MON_MSB:`MON_LSB]);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            monitor_output_pin <= 1'b0;
        else
        begin
            unique case (mon_sel)
                MON_OFF: monitor_output_pin <= 1'b0;
                MON_HIGH: monitor_output_pin <= 1'b1;
                MON_LOW: monitor_output_pin <= 1'b0;
                MON_R_DIV: monitor_output_pin <= pfd_tick;
                MON_N_DIV: monitor_output_pin <= n_tick;
                MON_LOCK_ANALOG: monitor_output_pin <= lock_analog;
                MON_LOCK_DIGITAL: monitor_output_pin <= lock_digital;
                MON_SPARE: monitor_output_pin <= 1'b0;
            endcase
        end
    end

    // The power-down pin overrides the RF enable and mute-until-lock settings only.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rf_out_on <= 1'b0;
            rf_power_level <= 2'h0;
            reference_differential <= 1'b0;
        end
        else
        begin
            rf_out_on <= latch[6][`RFEN_BIT]
                && rf_power_down_pin_b
                && (!latch[6][`MUTE_UNTIL_LOCK_BIT] || lock_digital);
            rf_power_level <= latch[6][`PWR_MSB:`PWR_LSB];
            reference_differential <= latch[6][`REFDIFF_BIT];
        end
    end

endmodule

// >>> rtl/serial_prog_host.sv
// Host controller: takes words over a register port and shifts them out on the three-wire link.
`timescale 1ns/10ps
`include "pll_cfg.svh"

module serial_prog_host
    import pll_pkg::*;
(
    // System.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port.
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    // Serial program link.
    serial_prog_if.host link
);

    localparam logic [7:0] HALF = 8'(`SCLK_HALF_CYCLES);

    host_state_t state;
    word_t word;
    logic [7:0] cnt;
    logic [4:0] bit_idx;
    logic r0_pending;
    logic range_err;
    logic start;
    logic check_err;
    logic [15:0] w_int;

    assign start = wr_stb && addr == `HOST_DATA_ADDR && state == HOST_IDLE;
    assign w_int = wdata[`INT_MSB:`INT_LSB];

    // Range checks on the word being sent; the word still goes out so software sees the flag.
    always_comb
    begin
        check_err = 1'b0;
        if (wdata[`SEL_MSB:`SEL_LSB] == `SEL_R0)
            check_err = wdata[`PRESC_BIT] ? (w_int < `INT_MIN_89)
                : (w_int < `INT_MIN_45 || w_int > `INT_MAX_45);
        else if (wdata[`SEL_MSB:`SEL_LSB] == `SEL_R2)
            check_err = wdata[`AUXILIARY_MODULUS_MSB:`AUXILIARY_MODULUS_LSB] < `AUXILIARY_MODULUS_MIN;
    end

    // Serial clock is derived from clk_sys; data changes only while the serial clock is low.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state <= HOST_IDLE;
            word <= 32'h00000000;
            cnt <= 8'h00;
            bit_idx <= 5'h00;
            link.sclk <= 1'b0;
            link.sdata <= 1'b0;
            link.load_strobe <= 1'b0;
        end
        else
        begin
            unique case (state)
                HOST_IDLE:
                begin
                    if (start)
                    begin
                        word <= wdata;
                        link.sdata <= wdata[31];
                        bit_idx <= 5'h1F;
                        cnt <= 8'h00;
                        state <= HOST_SHIFT;
                    end
                end
                HOST_SHIFT:
                begin
                    if (cnt == HALF - 8'h01)
                    begin
                        cnt <= 8'h00;
                        if (!link.sclk)
                            link.sclk <= 1'b1;
                        else
                        begin
                            link.sclk <= 1'b0;
                            if (bit_idx == 5'h00)
                                state <= HOST_LOAD;
                            else
                            begin
                                bit_idx <= bit_idx - 5'h01;
                                link.sdata <= word[bit_idx - 5'h01];
                            end
                        end
                    end
                    else
                        cnt <= cnt + 8'h01;
                end
                HOST_LOAD:
                begin
                    link.load_strobe <= 1'b1;
                    if (cnt == HALF)
                    begin
                        link.load_strobe <= 1'b0;
                        cnt <= 8'h00;
                        state <= HOST_IDLE;
                    end
                    else
                        cnt <= cnt + 8'h01;
                end
            endcase
        end
    end

    // Pending flag reminds software that held settings need a register 0 write.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            r0_pending <= 1'b0;
        else if (start)
        begin
            if (wdata[`SEL_MSB:`SEL_LSB] == `SEL_R0)
                r0_pending <= 1'b0;
            else if (wdata[`SEL_MSB:`SEL_LSB] == `SEL_R1 || wdata[`SEL_MSB:`SEL_LSB] == `SEL_R2
                || wdata[`SEL_MSB:`SEL_LSB] == `SEL_R4)
                r0_pending <= 1'b1;
        end
    end

    // Setting wins over a clear in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            range_err <= 1'b0;
        else if (start && check_err)
            range_err <= 1'b1;
        else if (wr_stb && addr == `HOST_STATUS_ADDR && wdata[`STAT_RANGE_ERR])
            range_err <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            rdata <= 32'h00000000;
        else if (rd_stb && addr == `HOST_DATA_ADDR)
            rdata <= word;
        else if (rd_stb && addr == `HOST_STATUS_ADDR)
            rdata <= {29'h00000000, range_err, r0_pending, state != HOST_IDLE};
        else
            rdata <= 32'h00000000;
    end

endmodule

// >>> verification/serial_prog_monitor.sv
// Wire checks on the three-wire program link between host and core.
`timescale 1ns/10ps
module serial_prog_monitor (
    // System.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Serial link.
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe
);
    logic [5:0] rises;
    logic sclk_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk_sys)
    begin
        sclk_q <= sclk;
    end
    // The count restarts on every strobe, so a short word is caught at its own strobe.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || load_strobe)
            rises <= 6'h00;
        else if (sclk && !sclk_q)
            rises <= rises + 6'h01;
    end
    sequence high_phase;
        sclk [*2] ##1 !sclk;
    endsequence
    // The host holds the strobe for two system clocks before it drops back to idle.
    sequence strobe_pulse;
        load_strobe [*2] ##1 !load_strobe;
    endsequence
    sclk_high_time_a: assert property ($rose(sclk) |-> high_phase)
        else $error("serial clock high time wrong");
    sclk_low_time_a: assert property ($fell(sclk) |-> !sclk [*2])
        else $error("serial clock low time wrong");
    data_stable_a: assert property ($changed(sdata) |-> !sclk)
        else $error("serial data moved while clock high");
    bit_count_a: assert property ($rose(load_strobe) |-> rises == 6'h20)
        else $error("word length not 32 bits");
    load_pulse_a: assert property ($rose(load_strobe) |-> strobe_pulse)
        else $error("load strobe width wrong");
    load_setup_a: assert property ($rose(load_strobe) |-> !sclk && !$past(sclk))
        else $error("load strobe too close to clock");
    load_quiet_a: assert property (load_strobe |-> !sclk)
        else $error("serial clock during load strobe");
    load_release_a: assert property ($fell(load_strobe) |-> !sclk ##1 !sclk)
        else $error("serial clock right after load strobe");
endmodule

// >>> verification/pll_serial_program_and_dividers_tb.sv
// Self-checking bench joining the host controller to the synthesizer core.
`timescale 1ns/10ps
`include "pll_cfg.svh"
module pll_serial_program_and_dividers_tb
    import pll_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h00000000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata;
    logic ref_tick = 1'b0;
    logic n_tick = 1'b0;
    logic lock_analog = 1'b0;
    logic lock_digital = 1'b0;
    logic pin_b = 1'b1;
    logic [15:0] int_value;
    logic prescaler_8_9;
    logic [23:0] primary_fraction_numerator;
    logic [13:0] auxiliary_fraction_numerator;
    logic [13:0] auxiliary_modulus;
    logic integer_mode;
    logic n_range_error;
    logic [9:0] r_count;
    logic reference_doubler;
    logic reference_half_divide;
    logic [3:0] cp_current;
    logic r_div_select;
    logic reference_differential;
    logic pfd_tick;
    logic monitor_output_pin;
    logic rf_out_on;
    logic [1:0] rf_power_level;
    word_t lat [0:8] = '{default: 32'h00000000};
    word_t act [0:8] = '{default: 32'h00000000};
    word_t sent = 32'h00000000;
    word_t shifted = 32'h00000000;
    word_t w;
    logic [31:0] v;
    int errors = 0;
    int checks_done = 0;
    int pulses = 0;
    int echoes = 0;
    int exp_ticks;
    int seed = 32'h1743;
    word_t tbl [0:9] = '{32'h00000001, 32'h00080002, 32'h00001000, 32'h00000160,
        32'h00000170, 32'h0007FFF0, 32'h00080000, 32'h001004A0, 32'h001004B0, 32'h001FFFF0};

    serial_prog_if lnk();
    serial_prog_host u_serial_prog_host (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .link(lnk));
    synth_ctrl_core u_synth_ctrl_core (.clk_sys(clk_sys), .rst_b(rst_b), .link(lnk),
        .ref_tick(ref_tick), .n_tick(n_tick), .lock_analog(lock_analog),
        .lock_digital(lock_digital), .rf_power_down_pin_b(pin_b), .int_value(int_value),
        .prescaler_8_9(prescaler_8_9), .primary_fraction_numerator(primary_fraction_numerator),
        .auxiliary_fraction_numerator(auxiliary_fraction_numerator),
        .auxiliary_modulus(auxiliary_modulus), .integer_mode(integer_mode),
        .n_range_error(n_range_error), .r_count(r_count), .reference_doubler(reference_doubler),
        .reference_half_divide(reference_half_divide), .cp_current(cp_current),
        .r_div_select(r_div_select), .reference_differential(reference_differential),
        .pfd_tick(pfd_tick), .monitor_output_pin(monitor_output_pin), .rf_out_on(rf_out_on),
        .rf_power_level(rf_power_level));
    serial_prog_monitor u_serial_prog_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
        .sclk(lnk.sclk), .sdata(lnk.sdata), .load_strobe(lnk.load_strobe));

    always #25 clk_sys = ~clk_sys;

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(negedge clk_sys);
        d = rdata;
        @(posedge clk_sys);
    endtask

    // Waits for the host to go idle, then updates the model the way the core should.
    task automatic settle(input word_t x);
        logic [31:0] s;
        s = 32'h00000001;
        for (int n = 0; n < 400 && s[0] !== 1'b0; n++)
            rd(4'h4, s);
        if (s[0] !== 1'b0)
        begin
            errors++;
            close_out();
        end
        if (x[3:0] <= 4'h8)
            lat[x[3:0]] = x;
        if (x[3:0] == 4'h0)
        begin
            act[1] = lat[1];
            act[2] = lat[2];
            act[4] = lat[4];
        end
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic send(input word_t x);
        sent = x;
        wr(4'h0, x);
        settle(x);
    endtask

    task automatic check_all();
        logic [15:0] iv;
        logic [2:0] ms;
        iv = lat[0][19:4];
        ms = lat[4][29:27];
        // Outputs are read away from the launching edge so they are settled.
        @(negedge clk_sys);
        chk(int_value, iv);
        chk(prescaler_8_9, lat[0][20]);
        chk(primary_fraction_numerator, act[1][27:4]);
        chk(auxiliary_fraction_numerator, act[2][17:4]);
        chk(auxiliary_modulus, act[2][31:18]);
        chk(integer_mode, act[1][27:4] == 24'h0 && act[2][17:4] == 14'h0);
        chk(n_range_error, lat[0][20] ? iv < 16'h004B : iv < 16'h0017 || iv > 16'h7FFF);
        chk({r_div_select, cp_current, reference_doubler, reference_half_divide, r_count},
            act[4][20:4]);
        chk(reference_differential, lat[0 + 6][30]);
        chk(rf_power_level, lat[6][5:4]);
        chk(rf_out_on, lat[6][6] & pin_b & (!lat[6][11] | lock_digital));
        chk(monitor_output_pin, ms == 3'h1 || ms == 3'h4 && n_tick || ms == 3'h5 && lock_analog
            || ms == 3'h6 && lock_digital);
        @(posedge clk_sys);
    endtask

    always @(posedge lnk.sclk)
        shifted <= {shifted[30:0], lnk.sdata};
    always @(posedge lnk.load_strobe)
        chk(shifted, sent);

    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check_all();
        rd(4'h9, v);
        chk(v, 32'h00000000);
        for (int k = 0; k < 40; k++)
        begin
            w = $random(seed);
            w[3:0] = k[3:0];
            {lock_analog, lock_digital, pin_b, n_tick} <= 4'($random(seed));
            send(w);
            check_all();
        end
        for (int k = 0; k < 10; k++)
        begin
            send(tbl[k]);
            check_all();
            rd(4'h4, v);
            if (k < 3)
                chk(v[1], k < 2);
        end
        chk(v[2], 1'b1);
        wr(4'h4, 32'h00000004);
        rd(4'h4, v);
        chk(v[2], 1'b0);
        for (int k = 0; k < 8; k++)
        begin
            {lock_analog, lock_digital, n_tick} <= 3'($random(seed));
            send({2'h0, k[2:0], 23'h0, 4'h4});
            check_all();
        end
        // Thirty reference ticks through a divide by three with the doubler on.
        send(32'h18008034);
        send(32'h00001000);
        check_all();
        exp_ticks = 30 * (1 + int'(act[4][15]));
        exp_ticks = exp_ticks / (int'(act[4][13:4]) * (1 + int'(act[4][14])));
        ref_tick <= 1'b1;
        for (int n = 1; n < 35; n++)
        begin
            @(posedge clk_sys);
            if (n == 30)
                ref_tick <= 1'b0;
            @(negedge clk_sys);
            pulses += pfd_tick;
            echoes += monitor_output_pin;
        end
        @(posedge clk_sys);
        chk(pulses, exp_ticks);
        chk(echoes, exp_ticks);
        // A second word while the first is still shifting must be dropped.
        // The strobe is held high across both words so it is never assigned twice in one step.
        w = 32'h40000876;
        sent = w;
        addr <= 4'h0;
        wdata <= w;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wdata <= 32'h00000006;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        settle(w);
        check_all();
        rd(4'h0, v);
        chk(v, w);
        close_out();
    end
endmodule
